// File: ccgts_core.sv
// Trim, status and lock tracking for the clock generator, AXI4-Lite slave
//
// Overview of operation
// - Eight-bit coarse trim drives oscillator period; larger value, longer period.
// - Sticky lost-lock flag sets when a locked active loop drops lock.
// - Lost-lock flag clears on reset or write one; write zero ignored.
// - Lost-lock flag raises interrupt only when its enable allows.
// - Lock bit shows active loop locked; detection off when loops disabled.
// - Changing source, loop or divider, trim in FLL/internal modes or multiplier in PLL/external modes clears lock until relock.
// - Stop entry clears lock until exit and relock of the active loop.
// - Low-power bypass entry clears lock until exit and relock.
// - Loop status reports active loop after synchronising the select.
// - Reference status reports source after synchronising the select.
// - Two-bit clock mode status updates after synchronising the select.
// - Oscillator ready sets after init cycles when oscillator requested and used.
// - Oscillator ready clears on request withdrawal or internal reference without enable.
// - Fine trim bit adds the smallest period step.
// - Lost-lock enable matters only while the flag is set.
// - Loop select disables the loop that is not chosen.
`timescale 1ns/1ps

module ccgts_core
    import ccgts_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_resetn,
    input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
    input  wire logic              i_s_axi_awvalid,
    output logic                   o_s_axi_awready,
    input  wire logic [31:0]       i_s_axi_wdata,
    input  wire logic [3:0]        i_s_axi_wstrb,
    input  wire logic              i_s_axi_wvalid,
    output logic                   o_s_axi_wready,
    output logic [1:0]             o_s_axi_bresp,
    output logic                   o_s_axi_bvalid,
    input  wire logic              i_s_axi_bready,
    input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
    input  wire logic              i_s_axi_arvalid,
    output logic                   o_s_axi_arready,
    output logic [31:0]            o_s_axi_rdata,
    output logic [1:0]             o_s_axi_rresp,
    output logic                   o_s_axi_rvalid,
    input  wire logic              i_s_axi_rready,
    input  wire ccgts_gen_s        i_gen_status,
    input  wire logic              i_stop_mode,
    output logic [7:0]             o_coarse_trim,
    output logic                   o_fine_trim,
    output ccgts_ctrl_s            o_ctrl,
    output logic                   o_fll_enable,
    output logic                   o_pll_enable,
    output logic                   o_irq
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [7:0] merge8(input logic [7:0] cur,
                                          input logic [7:0] nw,
                                          input logic       en);
        merge8 = en ? nw : cur;
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0]        ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0]        coarse_trim;
    logic              fine_trim;
    ccgts_ctrl_s       ctrl;
    logic              lost_lock_flag;
    logic              lock;
    logic              relock_pending;
    logic              osc_ready_flag;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    ccgts_gen_s        gen_meta;
    ccgts_gen_s        gen_sync;
    logic              aw_full;
    logic              w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;

    // ************************************************************
    // Bus write decode
    // ************************************************************
    wire logic        wr_fire  = aw_full && w_full && !o_s_axi_bvalid;
    wire logic        wr_trim  = wr_fire && hit(aw_addr, OFS_TRIM);
    wire logic        wr_sc    = wr_fire && hit(aw_addr, OFS_STATUS);
    wire logic        wr_ctrl  = wr_fire && hit(aw_addr, OFS_CTRL);
    wire logic        wr_irqst = wr_fire && hit(aw_addr, OFS_IRQ_ST);
    wire logic        wr_irqmk = wr_fire && hit(aw_addr, OFS_IRQ_MK);
    wire logic        wr_ok    = wr_trim || wr_sc || wr_ctrl ||
                                 wr_irqst || wr_irqmk;
    wire logic [7:0]  next_trim = merge8(coarse_trim, w_data[7:0],
                                         w_strb[0]);
    wire logic [15:0] ctrl_pad = {2'h0, ctrl};
    wire logic [15:0] ctrl_mrg = {merge8(ctrl_pad[15:8], w_data[15:8],
                                         w_strb[1]),
                                  merge8(ctrl_pad[7:0], w_data[7:0],
                                         w_strb[0])};
    wire ccgts_ctrl_s next_ctrl = ccgts_ctrl_s'(ctrl_mrg[CTRL_W-1:0]);
    // Write-one-to-clear on the lost-lock flag, from either view
    wire logic        lost_w1c = (wr_sc && w_strb[0] &&
                                  w_data[SC_LOST]) ||
                                 (wr_irqst && w_strb[0] &&
                                  w_data[IRQ_LOST]);
    wire logic [IRQ_W-1:0] irq_w1c = (wr_irqst && w_strb[0]) ?
                                     w_data[IRQ_W-1:0] : '0;

    // ************************************************************
    // Synchronised generator status and mode decode
    // ************************************************************
    wire logic        loop_choice_status = gen_sync.loop_ack;
    wire logic        ref_source_status  = gen_sync.ref_ack;
    wire ccgts_mode_e clock_mode_status  = gen_sync.mode_ack;
    wire logic        mode_fll = (clock_mode_status == CM_FLL);
    wire logic        mode_int = (clock_mode_status == CM_INT);
    wire logic        mode_ext = (clock_mode_status == CM_EXT);
    wire logic        mode_pll = (clock_mode_status == CM_PLL);
    wire logic        fll_int_modes = ref_source_status &&
                                      !loop_choice_status &&
                                      (mode_fll || mode_int);
    wire logic        pll_ext_modes = !ref_source_status &&
                                      loop_choice_status &&
                                      (mode_ext || mode_pll);
    wire logic        lp_bypass = ctrl.low_power &&
                                  (mode_int || mode_ext);
    wire logic        det_en    = !lp_bypass && !i_stop_mode;
    wire logic        raw_lock  = loop_choice_status ?
                                  gen_sync.pll_locked :
                                  gen_sync.fll_locked;
    wire logic        ext_in_use = ctrl.ext_ref_clk_en ||
                                   !ref_source_status;

    // ************************************************************
    // Lock tracking
    // ************************************************************
    // Parameter changes that invalidate the current lock
    wire logic        change_ev =
        (wr_ctrl &&
         ((next_ctrl.ref_source_select != ctrl.ref_source_select) ||
          (next_ctrl.loop_choice_select != ctrl.loop_choice_select) ||
          (next_ctrl.ref_divider != ctrl.ref_divider) ||
          (pll_ext_modes &&
           (next_ctrl.vco_multiplier != ctrl.vco_multiplier)))) ||
        (wr_trim && fll_int_modes && (next_trim != coarse_trim));
    wire logic        kill_lock = change_ev || !det_en;
    wire logic        lost_ev   = lock && !raw_lock && !kill_lock;
    wire logic        next_lock = raw_lock && !relock_pending &&
                                  !kill_lock;
    wire logic        osc_set   = ctrl.osc_request && ext_in_use &&
                                  gen_sync.osc_init_done;
    wire logic        osc_clr   = !ctrl.osc_request ||
                                  (ref_source_status &&
                                   !ctrl.ext_ref_clk_en);
    wire logic [IRQ_W-1:0] irq_ev = {osc_set && !osc_ready_flag,
                                     next_lock && !lock, lost_ev};

    // ************************************************************
    // Register processes
    // ************************************************************
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            gen_meta <= GEN_RST;
            gen_sync <= GEN_RST;
        end else begin
            gen_meta <= i_gen_status;
            gen_sync <= gen_meta;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            coarse_trim <= TRIM_RST;
            fine_trim   <= FINE_RST;
            ctrl        <= CTRL_RST;
            irq_mask    <= MASK_RST;
        end else begin
            if (wr_trim) begin
                coarse_trim <= next_trim;
            end
            if (wr_sc && w_strb[0]) begin
                fine_trim <= w_data[SC_FINE];
            end
            if (wr_ctrl) begin
                ctrl <= next_ctrl;
            end
            if (wr_irqmk && w_strb[0]) begin
                irq_mask <= w_data[IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            lock           <= 1'b0;
            relock_pending <= 1'b0;
            lost_lock_flag <= 1'b0;
            osc_ready_flag <= 1'b0;
            irq_status     <= '0;
        end else begin
            lock <= next_lock;
            // Armed by any lock killer, released once the loop drops
            relock_pending <= kill_lock || (relock_pending && raw_lock);
            // Set wins over a simultaneous clear
            lost_lock_flag <= lost_ev ||
                              (lost_lock_flag && !lost_w1c);
            osc_ready_flag <= osc_set || (osc_ready_flag && !osc_clr);
            irq_status     <= irq_ev | (irq_status & ~irq_w1c);
        end
    end

    // ************************************************************
    // AXI4-Lite handshakes
    // ************************************************************
    wire logic rd_fire = i_s_axi_arvalid && o_s_axi_arready;
    wire logic [31:0] rd_mux =
        hit(i_s_axi_araddr, OFS_TRIM)   ? {24'h0, coarse_trim} :
        hit(i_s_axi_araddr, OFS_STATUS) ?
            {24'h0, lost_lock_flag, lock, loop_choice_status,
             ref_source_status, clock_mode_status, osc_ready_flag,
             fine_trim} :
        hit(i_s_axi_araddr, OFS_CTRL)   ? {18'h0, ctrl} :
        hit(i_s_axi_araddr, OFS_IRQ_ST) ?
            {29'h0, irq_status[IRQ_W-1:1], lost_lock_flag} :
        hit(i_s_axi_araddr, OFS_IRQ_MK) ? {29'h0, irq_mask} : 32'h0;
    wire logic rd_ok = hit(i_s_axi_araddr, OFS_TRIM) ||
                       hit(i_s_axi_araddr, OFS_STATUS) ||
                       hit(i_s_axi_araddr, OFS_CTRL) ||
                       hit(i_s_axi_araddr, OFS_IRQ_ST) ||
                       hit(i_s_axi_araddr, OFS_IRQ_MK);

    assign o_s_axi_awready = !aw_full;
    assign o_s_axi_wready  = !w_full;
    assign o_s_axi_arready = !o_s_axi_rvalid;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            aw_full        <= 1'b0;
            w_full         <= 1'b0;
            aw_addr        <= '0;
            w_data         <= 32'h0;
            w_strb         <= 4'h0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (i_s_axi_awvalid && !aw_full) begin
                aw_full <= 1'b1;
                aw_addr <= i_s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full <= 1'b0;
            end
            if (i_s_axi_wvalid && !w_full) begin
                w_full <= 1'b1;
                w_data <= i_s_axi_wdata;
                w_strb <= i_s_axi_wstrb;
            end else if (wr_fire) begin
                w_full <= 1'b0;
            end
            if (wr_fire) begin
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata  <= 32'h0;
            o_s_axi_rresp  <= RESP_OKAY;
        end else if (rd_fire) begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata  <= rd_mux;
            o_s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Outputs toward the generator
    // ************************************************************
    assign o_coarse_trim = coarse_trim;
    assign o_fine_trim   = fine_trim;
    assign o_ctrl        = ctrl;
    // Only one loop powered at a time
    assign o_fll_enable  = !ctrl.loop_choice_select && !lp_bypass;
    assign o_pll_enable  = ctrl.loop_choice_select && !lp_bypass;
    // Enable has no effect unless the flag itself is set
    assign o_irq = (lost_lock_flag && irq_mask[IRQ_LOST]) ||
                   (|(irq_status[IRQ_W-1:1] &
                      irq_mask[IRQ_W-1:1]));

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    property p_lost_set;
        lock && !raw_lock && !kill_lock |=> lost_lock_flag;
    endproperty
    a_lost_set: assert property (p_lost_set)
        else $error("lost lock not flagged");

    property p_lost_clr;
        lost_lock_flag && lost_w1c && !lost_ev |=> !lost_lock_flag;
    endproperty
    a_lost_clr: assert property (p_lost_clr)
        else $error("lost lock flag not cleared by write one");

    property p_lost_hold;
        lost_lock_flag && !lost_w1c |=> lost_lock_flag;
    endproperty
    a_lost_hold: assert property (p_lost_hold)
        else $error("lost lock flag dropped without clear");

    property p_irq;
        lost_lock_flag |-> (o_irq == (irq_mask[IRQ_LOST] ||
            |(irq_status[IRQ_W-1:1] & irq_mask[IRQ_W-1:1])));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not follow lost lock enable");

    property p_change;
        change_ev |=> !lock;
    endproperty
    a_change: assert property (p_change)
        else $error("lock kept through a parameter change");

    property p_change_clr;
        change_ev && raw_lock |=> !lock [*2];
    endproperty
    a_change_clr: assert property (p_change_clr)
        else $error("lock survived a parameter change");

    property p_stop;
        i_stop_mode |=> !lock;
    endproperty
    a_stop: assert property (p_stop)
        else $error("lock set during stop");

    property p_bypass;
        lp_bypass ##1 lp_bypass |-> !lock;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("lock set in low power bypass");

    property p_loop_sync;
        $past(i_resetn, 2) |-> loop_choice_status ==
            $past(i_gen_status.loop_ack, 2);
    endproperty
    a_loop_sync: assert property (p_loop_sync)
        else $error("loop status not two stages behind");

    property p_mode_sync;
        $past(i_resetn, 2) |-> clock_mode_status ==
            $past(i_gen_status.mode_ack, 2);
    endproperty
    a_mode_sync: assert property (p_mode_sync)
        else $error("clock mode status not two stages behind");

    property p_osc_set;
        osc_set |=> osc_ready_flag;
    endproperty
    a_osc_set: assert property (p_osc_set)
        else $error("oscillator ready not set");

    property p_osc_clr;
        !ctrl.osc_request |=> !osc_ready_flag;
    endproperty
    a_osc_clr: assert property (p_osc_clr)
        else $error("oscillator ready kept after request withdrawn");

    property p_trim;
        wr_trim && w_strb[0] |=> o_coarse_trim == $past(w_data[7:0]);
    endproperty
    a_trim: assert property (p_trim)
        else $error("coarse trim not written");

    property p_loop_excl;
        !(o_fll_enable && o_pll_enable);
    endproperty
    a_loop_excl: assert property (p_loop_excl)
        else $error("both loops enabled");

endmodule

// File: ccgts_pkg.sv
// Shared constants and types for the clock generator trim and status block
package ccgts_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_TRIM   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CTRL   = 8'h08;
    localparam logic [7:0] OFS_IRQ_ST = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MK = 8'h10;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int         SC_LOST    = 7;
    localparam int         SC_LOCK    = 6;
    localparam int         SC_LOOPST  = 5;
    localparam int         SC_REFST   = 4;
    localparam int         SC_MODE_LO = 2;
    localparam int         SC_OSCRDY  = 1;
    localparam int         SC_FINE    = 0;
    localparam int         IRQ_LOST   = 0;
    localparam int         IRQ_LOCKED = 1;
    localparam int         IRQ_OSCRDY = 2;
    localparam int         IRQ_W      = 3;
    localparam int         CTRL_W     = 14;
    localparam logic [7:0] TRIM_RST   = 8'h80;
    localparam logic       FINE_RST   = 1'b0;
    localparam logic [2:0] MASK_RST   = 3'h0;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        CM_FLL = 2'b00,
        CM_INT = 2'b01,
        CM_EXT = 2'b10,
        CM_PLL = 2'b11
    } ccgts_mode_e;

    typedef struct packed {
        logic        low_power;
        logic        ext_ref_clk_en;
        logic        osc_request;
        logic [3:0]  vco_multiplier;
        logic        loop_choice_select;
        logic [2:0]  ref_divider;
        logic        ref_source_select;
        logic [1:0]  output_source_select;
    } ccgts_ctrl_s;

    localparam ccgts_ctrl_s CTRL_RST = '{
        low_power: 1'b0, ext_ref_clk_en: 1'b0, osc_request: 1'b0,
        vco_multiplier: 4'h1, loop_choice_select: 1'b0,
        ref_divider: 3'h0, ref_source_select: 1'b1,
        output_source_select: 2'h0};

    // Raw status from the loops, not yet synchronised
    typedef struct packed {
        logic        fll_locked;
        logic        pll_locked;
        logic        loop_ack;
        logic        ref_ack;
        ccgts_mode_e mode_ack;
        logic        osc_init_done;
    } ccgts_gen_s;

    localparam ccgts_gen_s GEN_RST = '{1'b0, 1'b0, 1'b0, 1'b1, CM_FLL, 1'b0};

endpackage

// File: ccgts_tb.sv
// Self-checking testbench for the clock generator trim and status block
`timescale 1ns/1ps

module tb
    import ccgts_pkg::*;
;
    // ************************************************************
    // Stimulus and bookkeeping
    // ************************************************************
    logic        clk = 1'b0, rstn = 1'b0, stop = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0]  bresp, rresp, rs;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0]  trim_o;
    logic        fine_o, fll_en, pll_en;
    ccgts_ctrl_s ctrl_o;
    ccgts_gen_s  gen = GEN_RST;
    int          fails = 0, checked = 0, cycles = 0;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d, e;
                    logic [1:0] r;} ccgts_row_s;
    ccgts_row_s  rows[$] = '{
        '{1'b0, OFS_TRIM, 32'h0, 32'h80, RESP_OKAY},
        '{1'b0, OFS_CTRL, 32'h0, 32'h84, RESP_OKAY},
        '{1'b0, OFS_STATUS, 32'h0, 32'h10, RESP_OKAY},
        '{1'b0, OFS_IRQ_MK, 32'h0, 32'h0, RESP_OKAY},
        '{1'b1, OFS_TRIM, 32'hA5, 32'hA5, RESP_OKAY},
        '{1'b1, OFS_TRIM, 32'h80, 32'h80, RESP_OKAY},
        '{1'b1, OFS_CTRL, 32'h2AAA, 32'h2AAA, RESP_OKAY},
        '{1'b1, OFS_CTRL, 32'h84, 32'h84, RESP_OKAY},
        '{1'b1, OFS_STATUS, 32'h7F, 32'h11, RESP_OKAY},
        '{1'b1, OFS_STATUS, 32'h0, 32'h10, RESP_OKAY},
        '{1'b1, 8'h14, 32'h5, 32'h0, RESP_SLVERR}};

    always #50 clk = ~clk;

    ccgts_core dut (.i_sys_clk(clk), .i_resetn(rstn),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready), .i_gen_status(gen), .i_stop_mode(stop),
        .o_coarse_trim(trim_o), .o_fine_trim(fine_o), .o_ctrl(ctrl_o),
        .o_fll_enable(fll_en), .o_pll_enable(pll_en), .o_irq(irq));

    // ************************************************************
    // Bus tasks and checks
    // ************************************************************
    // Handshakes sampled at the rising edge; an idle edge between calls
    // keeps a strobe from being dropped and raised in one time step
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                rs = bresp;
                bready <= 1'b0;
            end
        end
        @(posedge clk);
    endtask

    task automatic axr(input logic [7:0] a);
        logic done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                rd = rdata;
                rs = rresp;
                rready <= 1'b0;
            end
        end
        @(posedge clk);
    endtask

    task automatic chk(input logic [31:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic settle();
        repeat (5) @(posedge clk);
    endtask

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axw(rows[i].a, rows[i].d);
                chk(rs, rows[i].r, "bresp");
            end
            axr(rows[i].a);
            chk(rd, rows[i].e, "rdata");
            chk(rs, rows[i].r, "rresp");
        end
        $display("register table test done");
        // Lost lock, mask and write-one-to-clear
        gen.fll_locked <= 1'b1;
        settle();
        axr(OFS_STATUS);
        chk(rd, 32'h50, "locked");
        gen.fll_locked <= 1'b0;
        settle();
        axr(OFS_STATUS);
        chk(rd, 32'h90, "lost lock");
        chk(irq, 1'b0, "irq masked");
        axw(OFS_IRQ_MK, 32'h1);
        @(posedge clk);
        chk(irq, 1'b1, "irq unmasked");
        axw(OFS_STATUS, 32'h0);
        axr(OFS_STATUS);
        chk(rd, 32'h90, "write zero");
        axw(OFS_STATUS, 32'h80);
        axr(OFS_STATUS);
        chk(rd, 32'h10, "write one");
        @(posedge clk);
        chk(irq, 1'b0, "irq cleared");
        axw(OFS_IRQ_ST, 32'h7);
        $display("lost lock test done");
        // Lock killed by a trim change, then by stop entry
        for (int k = 0; k < 2; k++) begin
            gen.fll_locked <= 1'b1;
            settle();
            axr(OFS_STATUS);
            chk(rd & 32'h40, 32'h40, "relocked");
            if (k == 0) axw(OFS_TRIM, 32'h81);
            else begin
                stop <= 1'b1;
                @(posedge clk);
                stop <= 1'b0;
            end
            settle();
            axr(OFS_STATUS);
            chk(rd & 32'h40, 32'h0, "lock killed");
            gen.fll_locked <= 1'b0;
            settle();
        end
        $display("lock kill test done");
        // Oscillator ready set and withdrawn
        gen.ref_ack <= 1'b0;
        gen.osc_init_done <= 1'b1;
        axw(OFS_CTRL, 32'h884);
        settle();
        axr(OFS_STATUS);
        chk(rd & 32'h12, 32'h02, "osc ready");
        axw(OFS_CTRL, 32'h84);
        settle();
        axr(OFS_STATUS);
        chk(rd & 32'h02, 32'h0, "osc withdrawn");
        $display("oscillator test done");
        // Synchronised selection status
        gen.loop_ack <= 1'b1;
        gen.mode_ack <= CM_PLL;
        settle();
        axr(OFS_STATUS);
        chk(rd & 32'h3C, 32'h2C, "mode status");
        $display("status mirror test done");
        // Low power bypass, loop enables and outputs toward the generator
        gen.mode_ack <= CM_EXT;
        gen.pll_locked <= 1'b1;
        settle();
        axr(OFS_STATUS);
        chk(rd & 32'h40, 32'h40, "pll locked");
        chk({fll_en, pll_en}, 2'h2, "loop enables");
        axw(OFS_CTRL, 32'h2084);
        axw(OFS_STATUS, 32'h1);
        settle();
        axr(OFS_STATUS);
        chk(rd & 32'h41, 32'h01, "bypass lock");
        chk({fll_en, pll_en}, 2'h0, "bypass enables");
        chk({trim_o, fine_o}, {8'h81, 1'b1}, "trims out");
        chk(ctrl_o, 32'h2084, "ctrl out");
        $display("bypass test done");
        final_report();
    end
endmodule
